/* File: hw/djb_cfg.svh */
`ifndef DJB_CFG_SVH
`define DJB_CFG_SVH

// Register indices; byte address is four times the index
`define DJB_IDX_RSVD_A 14'h1236
`define DJB_IDX_RSVD_B 14'h1237
`define DJB_IDX_JOG_SPEED 14'h1238
`define DJB_IDX_JOG_HALT 14'h1239
`define DJB_IDX_RSVD_C 14'h123a
`define DJB_IDX_BOOST_SEL 14'h123b
`define DJB_IDX_BOOST_AMT 14'h123c
`define DJB_IDX_BOOST_KNEE 14'h123d
`define DJB_IDX_VF_PROFILE 14'h123e
`define DJB_IDX_VF_GAIN 14'h123f
`define DJB_IDX_AUTO_VCOMP 14'h1240
`define DJB_IDX_AUTO_SLIP 14'h1241
`define DJB_IDX_RSVD_BLK_LO 14'h1242
`define DJB_IDX_RSVD_BLK_HI 14'h1244
`define DJB_IDX_DC_BRAKE 14'h1245
`define DJB_IDX_STATUS 14'h1300

// Number of parameter words held
`define DJB_PRM_N 10

// Value limits, inclusive
`define DJB_MAX_JOG_SPEED 16'h03e7
`define DJB_MAX_JOG_HALT 16'h0005
`define DJB_MAX_BOOST_SEL 16'h0001
`define DJB_MAX_BOOST_AMT 16'h00c8
`define DJB_MAX_BOOST_KNEE 16'h01f4
`define DJB_MAX_VF_PROFILE 16'h0003
`define DJB_MIN_VF_GAIN 16'h0014
`define DJB_MAX_VF_GAIN 16'h0064
`define DJB_MAX_AUTO_GAIN 16'h00ff
`define DJB_MAX_DC_BRAKE 16'h0002
`define DJB_MIN_ZERO 16'h0000

// Halt codes up to this value are locked while running
`define DJB_HALT_LOCK_MAX 16'h0002

// Reset values
`define DJB_RST_JOG_SPEED 16'h0000
`define DJB_RST_JOG_HALT 16'h0000
`define DJB_RST_BOOST_SEL 16'h0000
`define DJB_RST_BOOST_AMT 16'h0000
`define DJB_RST_BOOST_KNEE 16'h0000
`define DJB_RST_VF_PROFILE 16'h0000
`define DJB_RST_VF_GAIN 16'h0064
`define DJB_RST_AUTO_VCOMP 16'h0064
`define DJB_RST_AUTO_SLIP 16'h0064
`define DJB_RST_DC_BRAKE 16'h0000

// Status register fields
`define DJB_STAT_RUN_BIT 0
`define DJB_STAT_REJ_BIT 1

// AXI responses
`define DJB_RESP_OKAY 2'h0
`define DJB_RESP_SLVERR 2'h2
`define DJB_RESP_DECERR 2'h3

`endif

/* File: hw/djb_param_bank.sv */
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "djb_cfg.svh"

// Summary of operation
// (RL1) Jog speed setpoint accepts start frequency up to 999 in 0.01 Hz steps.
// (RL2) Jog halt codes 0 coast, 1 ramp, 2 DC brake may change only while stopped.
// (RL3) Jog halt codes 3 coast, 4 ramp, 5 DC brake may also change while running.
// (RL4) Boost method select takes 0 for manual and 1 for automatic boost.
// (RL5) Manual boost amount holds 0 to 200 in 0.1 percent steps.
// (RL6) Manual boost knee point holds 0 to 500 in 0.1 percent of base frequency.
// (RL7) V/f profile takes 0 constant, 1 reduced, 2 user curve, 3 sensorless vector.
// (RL8) Automatic boost voltage compensation gain holds 0 to 255 percent.
// (RL9) Automatic boost slip compensation gain holds 0 to 255 percent.
// (RL10) DC brake enable takes 0 off, 1 on, 2 at set frequency only.
// (RL11) Reserved slots change nothing and read back no data.
// (RL12) An out-of-range write is refused and the register keeps its value.
module djb_param_bank
  import djb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic drive_running,
  input wire logic [15:0] start_freq,
  output djb_prm_t prm_out
);

  localparam int N = `DJB_PRM_N;

  // Word index of each parameter
  localparam logic [13:0] PRM_IDX [N] = '{
    `DJB_IDX_JOG_SPEED,
    `DJB_IDX_JOG_HALT,
    `DJB_IDX_BOOST_SEL,
    `DJB_IDX_BOOST_AMT,
    `DJB_IDX_BOOST_KNEE,
    `DJB_IDX_VF_PROFILE,
    `DJB_IDX_VF_GAIN,
    `DJB_IDX_AUTO_VCOMP,
    `DJB_IDX_AUTO_SLIP,
    `DJB_IDX_DC_BRAKE};

  // Lowest legal value; word 0 takes its floor from start_freq instead
  localparam logic [15:0] PRM_LO [N] = '{
    `DJB_MIN_ZERO,
    `DJB_MIN_ZERO,
    `DJB_MIN_ZERO,
    `DJB_MIN_ZERO,
    `DJB_MIN_ZERO,
    `DJB_MIN_ZERO,
    `DJB_MIN_VF_GAIN,
    `DJB_MIN_ZERO,
    `DJB_MIN_ZERO,
    `DJB_MIN_ZERO};

  // Highest legal value or code
  localparam logic [15:0] PRM_HI [N] = '{
    `DJB_MAX_JOG_SPEED,
    `DJB_MAX_JOG_HALT,
    `DJB_MAX_BOOST_SEL,
    `DJB_MAX_BOOST_AMT,
    `DJB_MAX_BOOST_KNEE,
    `DJB_MAX_VF_PROFILE,
    `DJB_MAX_VF_GAIN,
    `DJB_MAX_AUTO_GAIN,
    `DJB_MAX_AUTO_GAIN,
    `DJB_MAX_DC_BRAKE};

  // Value after reset
  localparam logic [15:0] PRM_RST [N] = '{
    `DJB_RST_JOG_SPEED,
    `DJB_RST_JOG_HALT,
    `DJB_RST_BOOST_SEL,
    `DJB_RST_BOOST_AMT,
    `DJB_RST_BOOST_KNEE,
    `DJB_RST_VF_PROFILE,
    `DJB_RST_VF_GAIN,
    `DJB_RST_AUTO_VCOMP,
    `DJB_RST_AUTO_SLIP,
    `DJB_RST_DC_BRAKE};
  localparam int HALT_W = 1;

  // State and its next value
  djb_state_t q;
  djb_state_t d;
  logic run_q;

  // Address decode
  logic [13:0] widx;
  logic [13:0] ridx;

  // Per-word tests and decisions
  logic [N-1:0] in_range;
  logic [N-1:0] w_hit;
  logic [N-1:0] r_hit;
  logic [N-1:0] w_ok;
  logic w_rsvd;
  logic r_rsvd;
  logic w_stat;
  logic r_stat;
  logic w_full;
  logic halt_lock;
  logic [31:0] rd_word;
  logic [1:0] rd_resp;

  // Run state arrives from the drive core, outside our clock
  djb_pin_sync u_run_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pin(drive_running),
    .level_q(run_q)
  );

  // Word index from byte address
  assign widx = s_axi_awaddr[15:2];
  assign ridx = s_axi_araddr[15:2];

  // One range test per parameter word; jog floor follows start frequency
  generate
    for (genvar g = 0; g < N; g++)
    begin : g_chk
      djb_range_chk u_chk (
        .value(s_axi_wdata[15:0]),
        .lo((g == 0) ? start_freq : PRM_LO[g]), // RL1
        .hi(PRM_HI[g]), // RL1 RL4 RL5 RL6 RL7 RL8 RL9 RL10
        .in_range(in_range[g])
      );
      // Address hits per word
      assign w_hit[g] = (widx == PRM_IDX[g]);
      assign r_hit[g] = (ridx == PRM_IDX[g]);
    end
  endgenerate

  // Reserved slots answer with an error and touch nothing
  assign w_rsvd = (widx == `DJB_IDX_RSVD_A)
    || (widx == `DJB_IDX_RSVD_B)
    || (widx == `DJB_IDX_RSVD_C)
    || ((widx >= `DJB_IDX_RSVD_BLK_LO) && (widx <= `DJB_IDX_RSVD_BLK_HI)); // RL11
  assign r_rsvd = (ridx == `DJB_IDX_RSVD_A)
    || (ridx == `DJB_IDX_RSVD_B)
    || (ridx == `DJB_IDX_RSVD_C)
    || ((ridx >= `DJB_IDX_RSVD_BLK_LO) && (ridx <= `DJB_IDX_RSVD_BLK_HI)); // RL11

  // Status word decode
  assign w_stat = (widx == `DJB_IDX_STATUS);
  assign r_stat = (ridx == `DJB_IDX_STATUS);

  // Writes lacking either low byte strobe are refused: a torn parameter could reach the drive
  assign w_full = (s_axi_wstrb[1:0] == 2'h3) && (s_axi_wdata[31:16] == 16'h0000);

  // Locked codes freeze the halt field while the motor turns
  // Only a move between unlocked codes gets through while running
  assign halt_lock = run_q && ((q.prm[HALT_W] <= `DJB_HALT_LOCK_MAX)
    || (s_axi_wdata[15:0] <= `DJB_HALT_LOCK_MAX)); // RL2 RL3

  // Per-word write acceptance
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      w_ok[i] = in_range[i] && w_full; // RL12
    end
    w_ok[HALT_W] = in_range[HALT_W] && w_full && !halt_lock; // RL2 RL3
  end

  // Read answer, formed while the address is still on the bus
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_resp = `DJB_RESP_DECERR;
    if (r_rsvd)
    begin
      rd_resp = `DJB_RESP_SLVERR; // RL11
    end
    if (r_stat)
    begin
      rd_resp = `DJB_RESP_OKAY;
      rd_word[`DJB_STAT_RUN_BIT] = run_q;
      rd_word[`DJB_STAT_REJ_BIT] = q.rej;
    end
    for (int i = 0; i < N; i++)
    begin
      if (r_hit[i])
      begin
        rd_resp = `DJB_RESP_OKAY;
        rd_word = {16'h0000, q.prm[i]};
      end
    end
  end

  // Bus sequencer and register update
  always_comb
  begin
    d = q;
    case (q.st)
      ST_IDLE:
      begin
        // Writes first; address and data are taken together
        if (s_axi_awvalid && s_axi_wvalid)
        begin
          d.awready = 1'b1;
          d.wready = 1'b1;
          d.st = ST_WTAKE;
        end
        else if (s_axi_arvalid)
        begin
          d.arready = 1'b1;
          d.st = ST_RTAKE;
        end
      end
      // Address and data are taken at this edge; commit or refuse
      ST_WTAKE:
      begin
        d.awready = 1'b0;
        d.wready = 1'b0;
        d.bvalid = 1'b1;
        // Unmapped unless a decode below claims the address
        d.bresp = `DJB_RESP_DECERR;
        // Status write only ever clears the sticky flag
        if (w_stat)
        begin
          d.bresp = `DJB_RESP_OKAY;
          if (s_axi_wstrb[0] && s_axi_wdata[`DJB_STAT_REJ_BIT])
          begin
            d.rej = 1'b0;
          end
        end
        if (w_rsvd)
        begin
          d.bresp = `DJB_RESP_SLVERR; // RL11
        end
        // A refused word keeps its value and raises the sticky flag
        for (int i = 0; i < N; i++)
        begin
          if (w_hit[i])
          begin
            if (w_ok[i])
            begin
              d.prm[i] = s_axi_wdata[15:0];
              d.bresp = `DJB_RESP_OKAY;
            end
            else
            begin
              d.bresp = `DJB_RESP_SLVERR; // RL12
              d.rej = 1'b1; // RL12
            end
          end
        end
        d.st = ST_BRESP;
      end
      // Response stands until the master takes it
      ST_BRESP:
      begin
        if (s_axi_bready)
        begin
          d.bvalid = 1'b0;
          d.st = ST_IDLE;
        end
      end
      // Address taken at this edge; the answer is latched with it
      ST_RTAKE:
      begin
        d.arready = 1'b0;
        d.rvalid = 1'b1;
        d.rdata = rd_word;
        d.rresp = rd_resp;
        d.st = ST_RDATA;
      end
      // Data stands until the master takes it
      ST_RDATA:
      begin
        if (s_axi_rready)
        begin
          d.rvalid = 1'b0;
          d.st = ST_IDLE;
        end
      end
      default:
      begin
        // Stray code: drop handshakes and return to idle
        d.awready = 1'b0;
        d.wready = 1'b0;
        d.arready = 1'b0;
        d.bvalid = 1'b0;
        d.rvalid = 1'b0;
        d.st = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      q <= '0;
      q.st <= ST_IDLE;
      // Parameters wake at their defaults, not at zero
      for (int i = 0; i < N; i++)
      begin
        q.prm[i] <= PRM_RST[i];
      end
    end
    else
    begin
      q <= d;
    end
  end

  // All outputs are fields of the state register
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_arready = q.arready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = q.rdata;
  assign prm_out = djb_prm_t'(q.prm);

endmodule

`default_nettype wire

/* File: hw/djb_pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none

// Three-stage pin synchroniser with agreement filter
module djb_pin_sync (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic pin,
  output logic level_q
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Level moves only when stages two and three agree
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
      begin
        level_q <= s3_q;
      end
    end
  end

endmodule

`default_nettype wire

/* File: hw/djb_pkg.sv */
package djb_pkg;

  // Bus-side sequencer, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_WTAKE = 5'h02,
    ST_BRESP = 5'h04,
    ST_RTAKE = 5'h08,
    ST_RDATA = 5'h10
  } djb_fsm_t;

  // Parameter words, word 0 is the jog speed setpoint
  typedef logic [9:0][15:0] djb_words_t;

  // Same layout as djb_words_t, named for the drive logic
  typedef struct packed {
    logic [15:0] dc_brake_enable;
    logic [15:0] auto_boost_slip_comp;
    logic [15:0] auto_boost_voltage_comp;
    logic [15:0] voltage_ratio_gain;
    logic [15:0] volts_per_hertz_profile;
    logic [15:0] manual_boost_knee_point;
    logic [15:0] manual_boost_amount;
    logic [15:0] boost_method_select;
    logic [15:0] jog_halt_behaviour;
    logic [15:0] jog_speed_setpoint;
  } djb_prm_t;

  // Whole state of the bank
  typedef struct packed {
    djb_fsm_t st;
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic rej;
    djb_words_t prm;
  } djb_state_t;

endpackage

/* File: hw/djb_range_chk.sv */
`timescale 1ns/1ns
`default_nettype none

// Inclusive range test on one parameter word
module djb_range_chk (
  input wire logic [15:0] value,
  input wire logic [15:0] lo,
  input wire logic [15:0] hi,
  output logic in_range
);

  // Both bounds inclusive
  assign in_range = (value >= lo) && (value <= hi);

endmodule

`default_nettype wire

/* File: sim/djb_param_bank_sva.sv */
`timescale 1ns/1ns
`default_nettype none

// Watches the bank from its ports only
module djb_param_bank_chk
  import djb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire djb_prm_t prm_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // Word index of the write being taken
  wire logic [13:0] widx = s_axi_awaddr[15:2];

  // Stored words, the V/f gain aside, never exceed their highest legal value
  chk_jog_max: assert property (prm_out.jog_speed_setpoint <= 16'h03e7)
    else $error("jog speed out of range");
  chk_halt_max: assert property (prm_out.jog_halt_behaviour <= 16'h0005)
    else $error("halt code out of range");
  chk_method_max: assert property (prm_out.boost_method_select <= 16'h0001)
    else $error("boost method out of range");
  chk_amount_max: assert property (prm_out.manual_boost_amount <= 16'h00c8)
    else $error("boost amount out of range");
  chk_knee_max: assert property (prm_out.manual_boost_knee_point <= 16'h01f4)
    else $error("knee point out of range");
  chk_profile_max: assert property (prm_out.volts_per_hertz_profile <= 16'h0003)
    else $error("profile out of range");
  chk_vcomp_max: assert property (prm_out.auto_boost_voltage_comp <= 16'h00ff)
    else $error("voltage gain out of range");
  chk_slip_max: assert property (prm_out.auto_boost_slip_comp <= 16'h00ff)
    else $error("slip gain out of range");
  chk_brake_max: assert property (prm_out.dc_brake_enable <= 16'h0002)
    else $error("brake code out of range");

  // Writes to holes, or of a jog speed above 999, answer an error and change nothing
  chk_rsvd_keep: assert property (s_axi_awready && (widx inside {14'h1236, 14'h1237,
    14'h123a, [14'h1242:14'h1244]}) |=> s_axi_bvalid && s_axi_bresp == 2'h2 && $stable(prm_out))
    else $error("reserved write not refused");
  chk_refuse_keep: assert property (s_axi_awready && widx == 14'h1238 &&
    s_axi_wdata[15:0] > 16'h03e7 |=> s_axi_bvalid && s_axi_bresp == 2'h2 && $stable(prm_out))
    else $error("bad jog write not refused");
endmodule

bind djb_param_bank djb_param_bank_chk u_chk (.sys_clk, .rst_b, .s_axi_awaddr, .s_axi_wdata,
  .s_axi_awready, .s_axi_bvalid, .s_axi_bresp, .prm_out);

`default_nettype wire

/* File: sim/test_djb_param_bank.sv */
`timescale 1ns/1ns
`default_nettype none

module test_djb_param_bank
  import djb_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] s_axi_awaddr = 16'h0000;
  logic [15:0] s_axi_araddr = 16'h0000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [2:0] prot = 3'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, drive_running = 1'b0;
  logic [15:0] start_freq = 16'h0032;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  djb_prm_t prm_out;
  logic [15:0] v;
  int err_total = 0, comparisons = 0, cyc = 0;
  // Parameter map: index, lowest legal, highest legal, value after reset
  logic [13:0] ix [10] = '{14'h1238, 14'h1239, 14'h123b, 14'h123c, 14'h123d, 14'h123e,
    14'h123f, 14'h1240, 14'h1241, 14'h1245};
  logic [15:0] lo [10] = '{16'h32, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h14, 16'h0, 16'h0, 16'h0};
  logic [15:0] hi [10] = '{16'h3e7, 16'h5, 16'h1, 16'hc8, 16'h1f4, 16'h3, 16'h64, 16'hff, 16'hff,
    16'h2};
  logic [15:0] rv [10] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h64, 16'h64, 16'h64, 16'h0};
  logic [13:0] rs [6] = '{14'h1236, 14'h1237, 14'h123a, 14'h1242, 14'h1243, 14'h1244};

  djb_param_bank u_dut (.sys_clk, .rst_b, .s_axi_awaddr, .s_axi_awprot(prot), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(prot), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .drive_running,
    .start_freq, .prm_out);

  initial forever #5 sys_clk = ~sys_clk;

  task summarize;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [13:0] i, input logic [15:0] d, input logic [1:0] e);
    logic a;
    logic w;
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    a = 1'b1;
    w = 1'b1;
    while (a || w)
    begin
      @(posedge sys_clk);
      if (s_axi_awready)
      begin
        a = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready)
      begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge sys_clk);
    chk("bresp", 32'(s_axi_bresp), 32'(e));
    s_axi_bready <= 1'b0;
    // Spare edge so the next call never drives bready twice in one step
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [13:0] i, input logic [31:0] d, input logic [1:0] e);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge sys_clk);
    chk("rresp", 32'(s_axi_rresp), 32'(e));
    chk("rdata", s_axi_rdata, d);
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Hang guard, well above the few hundred cycles the sequence needs
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      err_total++;
      summarize();
    end
  end

  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    // Reset value, each legal code or both ends, one step past the top end and one step below any nonzero floor
    for (int k = 0; k < 10; k++)
    begin
      rd(ix[k], {16'h0000, rv[k]}, 2'h0);
      if (lo[k] != 16'h0)
        wr(ix[k], lo[k] - 16'h1, 2'h2);
      for (v = lo[k]; v <= hi[k]; v = (hi[k] < 16'h6 || v == hi[k]) ? v + 16'h1 : hi[k])
      begin
        wr(ix[k], v, 2'h0);
        rd(ix[k], {16'h0000, v}, 2'h0);
      end
      wr(ix[k], hi[k] + 16'h1, 2'h2);
      rd(ix[k], {16'h0000, hi[k]}, 2'h0);
    end
    // Holes refuse, read zero and leave every word alone
    for (int k = 0; k < 6; k++)
    begin
      wr(rs[k], 16'h0001, 2'h2);
      rd(rs[k], 32'h0, 2'h2);
    end
    chk("jog", 32'(prm_out.jog_speed_setpoint), 32'h3e7);
    rd(14'h1000, 32'h0, 2'h3);
    // Partial strobe is refused rather than merged
    s_axi_wstrb <= 4'h1;
    wr(14'h1238, 16'h0040, 2'h2);
    s_axi_wstrb <= 4'hf;
    rd(14'h1238, 32'h3e7, 2'h0);
    // Running: only the 3..5 halt codes may be changed
    drive_running <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd(14'h1300, 32'h3, 2'h0);
    wr(14'h1239, 16'h0003, 2'h0);
    wr(14'h1239, 16'h0001, 2'h2);
    rd(14'h1239, 32'h3, 2'h0);
    drive_running <= 1'b0;
    repeat (6) @(posedge sys_clk);
    wr(14'h1239, 16'h0001, 2'h0);
    rd(14'h1239, 32'h1, 2'h0);
    chk("halt", 32'(prm_out.jog_halt_behaviour), 32'h1);
    // Sticky refusal flag survives until software clears it
    rd(14'h1300, 32'h2, 2'h0);
    wr(14'h1300, 16'h0002, 2'h0);
    rd(14'h1300, 32'h0, 2'h0);
    // Unmapped write answers a decode error and changes nothing
    wr(14'h1000, 16'h0001, 2'h3);
    rd(14'h1239, 32'h1, 2'h0);
    summarize();
  end
endmodule

`default_nettype wire
